// ==== drive_state_map.vh ====
// What this block does
// [RQ1] State changes only on new command word writes; init_done, errors and the auto run step also move it.
// [RQ2] State word always readable, shows current state.
// [RQ3] Command bits: 0,1,2,3 and 7 error clear.
// [RQ4] Shutdown pattern enters ready (2, 6, 8).
// [RQ5] Switch on pattern enters switched on (3, 5).
// [RQ6] All four bits run; ready passes through.
// [RQ7] Supply off or halt returns to inhibit.
// [RQ8] Halt while running goes straight to inhibit.
// [RQ9] Only transitions 2 to 10 and 15.
// [RQ10] Error clear rising edge leaves fault state.
// [RQ11] Error clear rising edge clears the warning.
// [RQ12] Outside fault, bits 0 to 3 decide.
// [RQ13] Master returns error clear to 0 afterwards.
// [RQ14] State word flag bits 6 down to 0.
// [RQ15] State word patterns per drive state.
// [RQ16] Not ready until init done, then inhibit.
// [RQ17] Internal error: reaction state, then fault.
// [RQ18] Mode select stored, active mode echoed.
// [RQ19] Read-only supported modes object.
// [RQ20] State word bit 7 shows pending warning.
// [RQ21] State word bit 9 shows command control.
// [RQ22] Unmatched command leaves state unchanged.
`ifndef DRIVE_STATE_MAP_VH
`define DRIVE_STATE_MAP_VH

`define OBJ_CMD_WORD 16'h6040
`define OBJ_STATE_WORD 16'h6041
`define OBJ_MODE_SEL 16'h6060
`define OBJ_MODE_DISP 16'h6061
`define OBJ_SUPP_MODES 16'h6502

`define CW_ENERGIZE 0
`define CW_SUPPLY 1
`define CW_HALT_NOT 2
`define CW_RUN 3
`define CW_ERR_CLR 7

`define SW_WARN 7
`define SW_REMOTE 9

`define CMD_WORD_RST 16'h0000
`define SPEED_MODE 8'h02
`define SUPP_MODES_VAL 32'h00000002

`define ST_NOT_READY 7'h01
`define ST_INHIBIT 7'h02
`define ST_READY 7'h04
`define ST_SWITCHED 7'h08
`define ST_RUNNING 7'h10
`define ST_ERR_REACT 7'h20
`define ST_FAULT 7'h40

`define TR_NONE 4'h0
`define TR_INIT 4'h1
`define TR_ERROR 4'hd
`define TR_SETTLE 4'he
`define TR_CLEAR 4'hf

`endif

// ==== drive_cmd_decode.v ====
`timescale 1ns/1ps
`include "drive_state_map.vh"

module drive_cmd_decode (
   input wire [6:0] state,
   input wire [3:0] cmd,
   output reg [6:0] nxt_state,
   output reg [3:0] trans,
   output reg auto_run
);

   localparam ST_INHIBIT = `ST_INHIBIT;
   localparam ST_READY = `ST_READY;
   localparam ST_SWITCHED = `ST_SWITCHED;
   localparam ST_RUNNING = `ST_RUNNING;

   wire energize;
   wire supply;
   wire halt_not;
   wire run_en;
   wire shutdown;
   wire switch_on;
   wire run_all;
   wire leave;

   assign energize = cmd[`CW_ENERGIZE];
   assign supply = cmd[`CW_SUPPLY];
   assign halt_not = cmd[`CW_HALT_NOT];
   assign run_en = cmd[`CW_RUN];
   assign shutdown = halt_not & supply & ~energize;
   assign switch_on = ~run_en & halt_not & supply & energize;
   assign run_all = run_en & halt_not & supply & energize;
   // Disable voltage and halt share the same targets.
   assign leave = ~supply | ~halt_not;

   always @* begin
      nxt_state = state; // [RQ22]
      trans = `TR_NONE;
      auto_run = 1'b0;
      case (state)
         ST_INHIBIT: begin
            if (shutdown) begin
               nxt_state = ST_READY; // [RQ4]
               trans = 4'h2;
            end
         end
         ST_READY: begin
            if (switch_on | run_all) begin
               nxt_state = ST_SWITCHED; // [RQ5]
               trans = 4'h3;
               auto_run = run_all; // [RQ6]
            end else if (leave) begin
               nxt_state = ST_INHIBIT; // [RQ7]
               trans = 4'h7;
            end
         end
         ST_SWITCHED: begin
            if (shutdown) begin
               nxt_state = ST_READY; // [RQ4]
               trans = 4'h6;
            end else if (run_all) begin
               nxt_state = ST_RUNNING; // [RQ6]
               trans = 4'h4;
            end else if (leave) begin
               nxt_state = ST_INHIBIT; // [RQ7]
               trans = 4'ha;
            end
         end
         ST_RUNNING: begin
            if (shutdown) begin
               nxt_state = ST_READY; // [RQ4]
               trans = 4'h8;
            end else if (switch_on) begin
               nxt_state = ST_SWITCHED; // [RQ5]
               trans = 4'h5;
            end else if (leave) begin
               // No halt-active state exists. [RQ8]
               nxt_state = ST_INHIBIT; // [RQ7]
               trans = 4'h9;
            end
         end
         default: begin
            nxt_state = state; // [RQ9]
         end
      endcase
   end

endmodule

// ==== drive_state_machine.v ====
`timescale 1ns/1ps
`include "drive_state_map.vh"

module drive_state_machine (
   input wire sys_clk,
   input wire reset,
   input wire clk_en,
   input wire obj_wr,
   input wire obj_rd,
   input wire [15:0] obj_index,
   input wire [15:0] obj_wdata,
   input wire init_done,
   input wire error_detect,
   input wire error_cause_done,
   input wire warning_event,
   input wire remote_enable,
   output reg [31:0] obj_rdata_ff,
   output reg obj_rvalid_ff,
   output reg obj_err_ff,
   output reg [15:0] state_word_ff,
   output reg [6:0] drive_state_ff,
   output reg [3:0] trans_ff,
   output reg run_permit_ff,
   output reg fault_clear_ff,
   output reg param_ok_ff,
   output reg [7:0] mode_disp_ff
);

   localparam ST_NOT_READY = `ST_NOT_READY;
   localparam ST_INHIBIT = `ST_INHIBIT;
   localparam ST_READY = `ST_READY;
   localparam ST_SWITCHED = `ST_SWITCHED;
   localparam ST_RUNNING = `ST_RUNNING;
   localparam ST_ERR_REACT = `ST_ERR_REACT;
   localparam ST_FAULT = `ST_FAULT;

   ////////////////////////////////////////////////////////////////////////
   // State word flag pattern for a drive state.

   function [6:0] state_flags;
      input [6:0] st;
      input power_on;
      begin
         case (st)
            ST_NOT_READY: state_flags = {2'b00, power_on, 4'b0000}; // [RQ15]
            ST_INHIBIT: state_flags = {2'b11, power_on, 4'b0000}; // [RQ15]
            ST_READY: state_flags = {2'b01, power_on, 4'b0001}; // [RQ15]
            ST_SWITCHED: state_flags = 7'h33; // [RQ15]
            ST_RUNNING: state_flags = 7'h37; // [RQ15]
            ST_ERR_REACT: state_flags = {2'b01, power_on, 4'b1111}; // [RQ15]
            ST_FAULT: state_flags = {2'b01, power_on, 4'b1000}; // [RQ15]
            default: state_flags = 7'h00;
         endcase
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Registers.

   reg [15:0] cmd_ff;
   reg [7:0] mode_sel_ff;
   reg warn_ff;
   reg auto_ff;

   reg [6:0] nxt_drive_state;
   reg [3:0] nxt_trans;
   reg nxt_warn;
   reg nxt_auto;
   reg nxt_fault_clear;
   reg [31:0] nxt_obj_rdata;
   reg nxt_obj_err;
   reg [7:0] nxt_mode_disp;

   ////////////////////////////////////////////////////////////////////////
   // Object access decode.

   wire wr_cmd;
   wire wr_mode;
   wire wr_ro;
   wire wr_bad;
   wire mode_ok;
   wire clr_edge;
   wire [6:0] dec_state;
   wire [3:0] dec_trans;
   wire dec_auto;
   wire supply_now;
   wire [6:0] flags;

   assign wr_cmd = obj_wr & (obj_index == `OBJ_CMD_WORD); // [RQ1]
   assign wr_mode = obj_wr & (obj_index == `OBJ_MODE_SEL);
   assign wr_ro = obj_wr & ((obj_index == `OBJ_STATE_WORD) |
                            (obj_index == `OBJ_MODE_DISP) |
                            (obj_index == `OBJ_SUPP_MODES)); // [RQ19]
   assign wr_bad = obj_wr & ~wr_cmd & ~wr_mode & ~wr_ro;
   assign mode_ok = (obj_wdata[7:0] == `SPEED_MODE); // [RQ18]

   // The edge is judged against the last written word, so a held 1 never
   // retriggers; the master must write 0 again before the next clear.
   assign clr_edge = wr_cmd & obj_wdata[`CW_ERR_CLR] &
                     ~cmd_ff[`CW_ERR_CLR]; // [RQ10] [RQ13]

   drive_cmd_decode u_decode (
      .state(drive_state_ff),
      .cmd(obj_wdata[3:0]), // [RQ12]
      .nxt_state(dec_state),
      .trans(dec_trans),
      .auto_run(dec_auto)
   );

   ////////////////////////////////////////////////////////////////////////
   // Next drive state.

   always @* begin
      nxt_drive_state = drive_state_ff;
      nxt_trans = `TR_NONE;
      nxt_auto = 1'b0;
      nxt_fault_clear = 1'b0;
      case (drive_state_ff)
         ST_NOT_READY: begin
            if (init_done) begin
               nxt_drive_state = ST_INHIBIT; // [RQ16]
               nxt_trans = `TR_INIT;
            end
         end
         ST_ERR_REACT: begin
            if (error_cause_done) begin
               nxt_drive_state = ST_FAULT; // [RQ17]
               nxt_trans = `TR_SETTLE;
            end
         end
         ST_FAULT: begin
            if (clr_edge) begin
               nxt_drive_state = ST_INHIBIT; // [RQ10]
               nxt_trans = `TR_CLEAR;
               nxt_fault_clear = 1'b1;
            end
         end
         ST_INHIBIT, ST_READY, ST_SWITCHED, ST_RUNNING: begin
            if (error_detect) begin
               nxt_drive_state = ST_ERR_REACT; // [RQ17]
               nxt_trans = `TR_ERROR;
            end else if (wr_cmd & remote_enable) begin
               nxt_drive_state = dec_state; // [RQ1] [RQ9]
               nxt_trans = dec_trans;
               nxt_auto = dec_auto; // [RQ6]
            end else if (auto_ff & remote_enable &
                         (drive_state_ff == ST_SWITCHED) &
                         (cmd_ff[3:0] == 4'hf)) begin
               // Second half of the combined switch-on and enable.
               nxt_drive_state = ST_RUNNING; // [RQ6]
               nxt_trans = 4'h4;
            end
         end
         default: begin
            nxt_drive_state = ST_NOT_READY;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // Warning flag; a new warning in the clearing cycle survives.

   always @* begin
      nxt_warn = warn_ff;
      if (clr_edge) begin
         nxt_warn = 1'b0; // [RQ11]
      end
      if (warning_event) begin
         nxt_warn = 1'b1; // [RQ20]
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Object read answer and access errors.

   always @* begin
      nxt_obj_rdata = 32'h00000000;
      nxt_obj_err = wr_ro | wr_bad | (wr_mode & ~mode_ok);
      if (obj_rd) begin
         case (obj_index)
            `OBJ_CMD_WORD: nxt_obj_rdata = {16'h0000, cmd_ff};
            `OBJ_STATE_WORD: nxt_obj_rdata = {16'h0000, state_word_ff}; // [RQ2]
            `OBJ_MODE_SEL: nxt_obj_rdata = {24'h000000, mode_sel_ff};
            `OBJ_MODE_DISP: nxt_obj_rdata = {24'h000000, mode_disp_ff};
            `OBJ_SUPP_MODES: nxt_obj_rdata = `SUPP_MODES_VAL; // [RQ19]
            default: nxt_obj_err = 1'b1;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Mode display follows only a supported selection.

   always @* begin
      nxt_mode_disp = mode_disp_ff;
      if (wr_mode & mode_ok) begin
         nxt_mode_disp = obj_wdata[7:0]; // [RQ18]
      end
   end

   // Bit 4 is free in some states; it follows the supply enable command,
   // taken from a write in flight so the flag never lags the state.
   assign supply_now = wr_cmd ? obj_wdata[`CW_SUPPLY] : cmd_ff[`CW_SUPPLY];
   assign flags = state_flags(nxt_drive_state,
                              supply_now); // [RQ14] [RQ15]

   ////////////////////////////////////////////////////////////////////////
   // Clocked state.

   always @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         cmd_ff <= `CMD_WORD_RST;
         mode_sel_ff <= `SPEED_MODE;
         mode_disp_ff <= `SPEED_MODE;
         warn_ff <= 1'b0;
         auto_ff <= 1'b0;
         drive_state_ff <= ST_NOT_READY; // [RQ16]
         trans_ff <= `TR_NONE;
         state_word_ff <= 16'h0000;
         run_permit_ff <= 1'b0;
         fault_clear_ff <= 1'b0;
         param_ok_ff <= 1'b0;
         obj_rdata_ff <= 32'h00000000;
         obj_rvalid_ff <= 1'b0;
         obj_err_ff <= 1'b0;
      end else if (clk_en) begin
         if (wr_cmd) begin
            cmd_ff <= obj_wdata; // [RQ3]
         end
         if (wr_mode) begin
            mode_sel_ff <= obj_wdata[7:0]; // [RQ18]
         end
         mode_disp_ff <= nxt_mode_disp;
         warn_ff <= nxt_warn;
         auto_ff <= nxt_auto;
         drive_state_ff <= nxt_drive_state;
         trans_ff <= nxt_trans;
         state_word_ff <= {6'b000000, remote_enable, 1'b0, nxt_warn,
                           flags}; // [RQ2] [RQ20] [RQ21]
         run_permit_ff <= (nxt_drive_state == ST_RUNNING);
         fault_clear_ff <= nxt_fault_clear;
         // Parameters may be set in every state once initialised.
         param_ok_ff <= (nxt_drive_state != ST_NOT_READY); // [RQ16]
         obj_rdata_ff <= nxt_obj_rdata;
         obj_rvalid_ff <= obj_rd;
         obj_err_ff <= nxt_obj_err;
      end
   end

endmodule

// ==== drive_state_machine_properties.sv ====
`timescale 1ns/1ps
module drive_state_checker (
   input wire sys_clk,
   input wire reset,
   input wire clk_en,
   input wire obj_wr,
   input wire obj_rd,
   input wire [15:0] obj_index,
   input wire [15:0] obj_wdata,
   input wire error_detect,
   input wire error_cause_done,
   input wire remote_enable,
   input wire [31:0] obj_rdata_ff,
   input wire obj_rvalid_ff,
   input wire [15:0] state_word_ff,
   input wire [6:0] drive_state_ff,
   input wire [3:0] trans_ff,
   input wire fault_clear_ff,
   input wire run_permit_ff,
   input wire param_ok_ff,
   input wire [7:0] mode_disp_ff
);
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (reset);
   ////////////////////////////////////////////////////////////////////
   state_read_a: assert property (clk_en && obj_rd &&
      obj_index == 16'h6041 |=> obj_rvalid_ff &&
      obj_rdata_ff[15:0] == $past(state_word_ff))
      else $error("State word read answered wrongly.");
   one_state_a: assert property ($onehot(drive_state_ff))
      else $error("Drive state is not one-hot.");
   on_pattern_a: assert property (drive_state_ff == 7'h08
      |-> state_word_ff[6:0] == 7'h33)
      else $error("Switched on pattern wrong.");
   run_pattern_a: assert property (drive_state_ff == 7'h10
      |-> state_word_ff[6:0] == 7'h37)
      else $error("Operation enabled pattern wrong.");
   fault_exit_a: assert property (fault_clear_ff |-> trans_ff ==
      4'hf && drive_state_ff == 7'h02 && $past(drive_state_ff) == 7'h40)
      else $error("Fault clear without fault exit.");
   state_hold_a: assert property (clk_en && !obj_wr &&
      !error_detect && (drive_state_ff == 7'h02 ||
      drive_state_ff == 7'h10) |=> $stable(drive_state_ff))
      else $error("State moved without a command.");
   halt_direct_a: assert property (clk_en &&
      drive_state_ff == 7'h10 && obj_wr && obj_index == 16'h6040 &&
      obj_wdata[2:1] == 2'b01 && remote_enable && !error_detect |=>
      drive_state_ff == 7'h02 && trans_ff == 4'h9)
      else $error("Halt did not go straight to inhibit.");
   fault_settle_a: assert property (clk_en &&
      drive_state_ff == 7'h20 && error_cause_done |=>
      drive_state_ff == 7'h40)
      else $error("Error reaction did not settle.");
   run_flag_a: assert property (run_permit_ff ==
      (drive_state_ff == 7'h10))
      else $error("Run permit does not match the state.");
   param_gate_a: assert property (param_ok_ff ==
      (drive_state_ff != 7'h01))
      else $error("Parameter gate does not match the state.");
   mode_echo_a: assert property (mode_disp_ff == 8'h02)
      else $error("Mode display left velocity mode.");
endmodule
bind drive_state_machine drive_state_checker drive_state_checker_i (
   .sys_clk, .reset, .clk_en, .obj_wr, .obj_rd, .obj_index, .obj_wdata,
   .error_detect, .error_cause_done, .remote_enable, .obj_rdata_ff,
   .obj_rvalid_ff, .state_word_ff, .drive_state_ff, .trans_ff,
   .fault_clear_ff, .run_permit_ff, .param_ok_ff, .mode_disp_ff);

// ==== bus_master_model.sv ====
`timescale 1ns/1ps
module bus_master_model (
   input wire sys_clk,
   output reg obj_wr,
   output reg obj_rd,
   output reg [15:0] obj_index,
   output reg [15:0] obj_wdata
);
   initial begin
      obj_wr = 1'b0;
      obj_rd = 1'b0;
      obj_index = 16'h0;
      obj_wdata = 16'h0;
   end
   // One access per call; the data word carries the command bits.
   task access(input logic w, input logic [15:0] i, input logic [15:0] d);
      begin
         @(negedge sys_clk);
         obj_wr = w;
         obj_rd = !w;
         obj_index = i;
         obj_wdata = d;
         @(negedge sys_clk);
         obj_wr = 1'b0;
         obj_rd = 1'b0;
         // Released lines flip so a stale value is never mistaken.
         obj_index = ~i;
         obj_wdata = ~d;
      end
   endtask
endmodule

// ==== tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
   reg sys_clk = 1'b0;
   reg reset = 1'b1;
   reg init_done = 1'b0;
   reg error_detect = 1'b0;
   reg error_cause_done = 1'b0;
   reg warning_event = 1'b0;
   reg remote_enable = 1'b1;
   reg clk_en = 1'b1;
   wire obj_wr;
   wire obj_rd;
   wire [15:0] obj_index;
   wire [15:0] obj_wdata;
   wire [31:0] obj_rdata_ff;
   wire obj_rvalid_ff;
   wire obj_err_ff;
   int num_errors = 0;
   int num_checks = 0;
   int cycles = 0;
   int k;
   logic [33:0] notes [$];
   logic [33:0] n;
   logic [15:0] cmd_t [0:17] = '{16'h7, 16'h6, 16'h7, 16'hf, 16'h7,
      16'h6, 16'hf, 16'h6, 16'hf, 16'hb, 16'h6, 16'h5, 16'h6, 16'h7,
      16'h0, 16'h6, 16'h7, 16'hf};
   logic [15:0] exp_t [0:17] = '{16'h270, 16'h231, 16'h233, 16'h237,
      16'h233, 16'h231, 16'h237, 16'h231, 16'h237, 16'h270, 16'h231,
      16'h260, 16'h231, 16'h233, 16'h260, 16'h231, 16'h233, 16'h237};
   initial forever #2.5 sys_clk = ~sys_clk;
   bus_master_model master_i (.sys_clk(sys_clk), .obj_wr(obj_wr),
      .obj_rd(obj_rd), .obj_index(obj_index), .obj_wdata(obj_wdata));
   drive_state_machine drive_state_machine_i (.sys_clk(sys_clk),
      .reset(reset), .clk_en(clk_en), .obj_wr(obj_wr), .obj_rd(obj_rd),
      .obj_index(obj_index), .obj_wdata(obj_wdata),
      .init_done(init_done), .error_detect(error_detect),
      .error_cause_done(error_cause_done),
      .warning_event(warning_event), .remote_enable(remote_enable),
      .obj_rdata_ff(obj_rdata_ff), .obj_rvalid_ff(obj_rvalid_ff),
      .obj_err_ff(obj_err_ff), .state_word_ff(), .drive_state_ff(),
      .trans_ff(), .run_permit_ff(), .fault_clear_ff(), .param_ok_ff(),
      .mode_disp_ff());
   ////////////////////////////////////////////////////////////////////
   task check(input logic [31:0] seen, input logic [31:0] exp);
      begin
         num_checks++;
         if (seen !== exp) begin
            num_errors++;
            $display("wrong value at %0t: saw %h want %h", $time, seen,
               exp);
         end
      end
   endtask
   task complete_run;
      begin
         $display("checks %0d errors %0d", num_checks, num_errors);
         if (num_errors == 0 && num_checks > 0) begin
            $display("All tests passed");
         end else begin
            $display("Some tests failed");
         end
         $finish;
      end
   endtask
   task wr(input logic [15:0] i, input logic [15:0] d, input logic e);
      begin
         if (e) notes.push_back({2'b01, 32'h0});
         master_i.access(1'b1, i, d);
      end
   endtask
   task rd(input logic [15:0] i, input logic [32:0] x);
      begin
         notes.push_back({1'b1, x});
         master_i.access(1'b0, i, 16'h0);
      end
   endtask
   task idle(input int c);
      repeat (c) @(negedge sys_clk);
   endtask
   // Each answer is matched against the oldest note.
   always @(negedge sys_clk) begin
      if (obj_rvalid_ff === 1'b1 || obj_err_ff === 1'b1) begin
         n = notes.size() ? notes.pop_front() : 34'h3ffffffff;
         check({31'h0, obj_err_ff}, {31'h0, n[32]});
         if (n[33]) check(obj_rdata_ff, n[31:0]);
      end
   end
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 5000) begin
         num_errors++;
         complete_run;
      end
   end
   initial begin
      void'($urandom(32'h42fb3a55));
      idle(10);
      reset = 1'b0;
      rd(16'h6041, {1'b0, 32'h200});
      rd(16'h6061, {1'b0, 32'h2});
      rd(16'h6502, {1'b0, 32'h2});
      init_done = 1'b1;
      remote_enable = 1'b0;
      wr(16'h6040, 16'h6, 1'b0);
      rd(16'h6041, {1'b0, 32'h70});
      remote_enable = 1'b1;
      $display("test init done");
      for (k = 0; k < 18; k++) begin
         wr(16'h6040, cmd_t[k], 1'b0);
         idle(2);
         rd(16'h6041, {17'h0, exp_t[k]});
      end
      $display("test transitions done");
      error_detect = 1'b1;
      idle(2);
      rd(16'h6041, {1'b0, 32'h23f});
      error_cause_done = 1'b1;
      idle(1);
      error_cause_done = 1'b0;
      error_detect = 1'b0;
      rd(16'h6041, {1'b0, 32'h238});
      wr(16'h6040, 16'h80, 1'b0);
      rd(16'h6041, {1'b0, 32'h260});
      wr(16'h6040, 16'h0, 1'b0);
      wr(16'h6040, 16'h80, 1'b0);
      error_detect = 1'b1;
      error_cause_done = 1'b1;
      idle(3);
      error_detect = 1'b0;
      error_cause_done = 1'b0;
      // A bit that stays high must not clear the fault.
      wr(16'h6040, 16'h80, 1'b0);
      rd(16'h6041, {1'b0, 32'h228});
      wr(16'h6040, 16'h0, 1'b0);
      wr(16'h6040, 16'h80, 1'b0);
      rd(16'h6041, {1'b0, 32'h260});
      wr(16'h6040, 16'h0, 1'b0);
      $display("test fault done");
      warning_event = 1'b1;
      idle(1);
      warning_event = 1'b0;
      rd(16'h6041, {1'b0, 32'h2e0});
      wr(16'h6040, 16'h80, 1'b0);
      rd(16'h6041, {1'b0, 32'h260});
      wr(16'h6040, 16'h0, 1'b0);
      $display("test warning done");
      // A write while the clock enable is low must leave no trace.
      clk_en = 1'b0;
      wr(16'h6040, 16'h6, 1'b0);
      clk_en = 1'b1;
      rd(16'h6041, {1'b0, 32'h260});
      rd(16'h6040, {1'b0, 32'h0});
      $display("test enable done");
      wr(16'h6041, 16'h6, 1'b1);
      rd(16'h1234, {1'b1, 32'h0});
      wr(16'h6060, 16'h3 + 16'($urandom % 253), 1'b1);
      wr(16'h6060, 16'h2, 1'b0);
      rd(16'h6061, {1'b0, 32'h2});
      rd(16'h6060, {1'b0, 32'h2});
      idle(4);
      check(notes.size(), 32'h0);
      $display("test objects done");
      complete_run;
   end
endmodule
